// File: pkg/mxd_pkg.sv
// Purpose: constants and types for the instruction execution datapath
// Assumes: 8-bit data path, 16-bit program words, one core clock
// Notes: register port map, flag layout, opcodes and carriers
// Operation
// - skip-zero-with-move copies byte to working register, skips if zero, no flags
// - a met skip adds one dummy cycle; otherwise execution just continues
// - bit-test skip skips when selected bit is zero, flags untouched
// - specific-page table read uses high:low pointer, low to memory, high to latch
// - final-page table read uses low pointer on last page, same byte split
// - preincrement reads bump the low pointer first, then read with new value
// - xor with memory to register or memory, or with immediate to register, zero flag only
// - extended forms address any data memory section directly
// - extended add, optional carry in, updates range, zero, aux, carry, signed carry
// - extended and/or to register or memory, zero flag only
// - extended clear writes 00h, bit form clears one bit, no flags
// - extended complement inverts byte in place or to register, zero flag
// - decimal adjust adds six per nibble above nine or with its carry
// - decimal adjust stores to memory, only carry may change
// - increment and decrement by one, in place or to register, zero flag
// - extended move between memory and working register, no flags
// - rotate left moves bit 7 to bit 0, no flags, in place or register
// - rotate left through carry, bit 7 to carry, old carry to bit 0
package mxd_pkg;
  // register port offsets
  localparam logic [3:0] REG_WORKING = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_PTR_LOW = 4'h2;
  localparam logic [3:0] REG_PTR_HIGH = 4'h3;
  localparam logic [3:0] REG_HIGH_LATCH = 4'h4;
  // reset values
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // arithmetic constants
  localparam logic [7:0] CLEAR_VALUE = 8'h00;
  localparam logic [3:0] NIBBLE_MAX = 4'h9;
  localparam logic [3:0] BCD_STEP = 4'h6;
  localparam logic [7:0] ONE = 8'h01;

  typedef enum logic [5:0] {
    op_skip_zero_with_move = 6'h00,
    op_skip_if_zero = 6'h01,
    op_skip_if_zero_bit = 6'h02,
    op_table_read_specific_page = 6'h03,
    op_table_read_final_page = 6'h04,
    op_preincrement_table_read = 6'h05,
    op_preincrement_final_page_read = 6'h06,
    op_xor_work = 6'h07,
    op_xor_mem = 6'h08,
    op_xor_imm = 6'h09,
    op_extended_add = 6'h0a,
    op_extended_add_mem = 6'h0b,
    op_extended_add_with_carry = 6'h0c,
    op_extended_add_with_carry_mem = 6'h0d,
    op_extended_bitwise_and = 6'h0e,
    op_extended_bitwise_and_mem = 6'h0f,
    op_extended_bitwise_or = 6'h10,
    op_extended_bitwise_or_mem = 6'h11,
    op_extended_clear = 6'h12,
    op_extended_clear_bit = 6'h13,
    op_extended_complement = 6'h14,
    op_extended_complement_work = 6'h15,
    op_extended_decimal_adjust = 6'h16,
    op_extended_decrement = 6'h17,
    op_extended_decrement_work = 6'h18,
    op_extended_increment = 6'h19,
    op_extended_increment_work = 6'h1a,
    op_extended_move_to_work = 6'h1b,
    op_extended_move_to_mem = 6'h1c,
    op_extended_rotate_left = 6'h1d,
    op_extended_rotate_left_work = 6'h1e,
    op_extended_rotate_left_carry = 6'h1f,
    op_extended_rotate_left_carry_work = 6'h20
  } mxd_op_type;

  // status layout, bit 0 is carry
  typedef struct packed {
    logic signed_carry_flag;
    logic signed_range_exceeded_flag;
    logic z;
    logic auxiliary_carry_flag;
    logic c;
  } mxd_flags_type;

  typedef struct packed {
    mxd_op_type op;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } mxd_cmd_type;

  typedef struct packed {
    logic [7:0] value;
    logic to_work;
    logic to_mem;
    logic skip;
    mxd_flags_type flags;
  } mxd_result_type;
endpackage

// File: design/mxd_core.sv
// Purpose: executes one datapath instruction per command
// Assumes: data and program memory answer one cycle after a read strobe
// Notes: fixed three-cycle command, one extra dummy cycle after a skip
`timescale 1ns/10ps
module mxd_core #(
  parameter int DAW = 12,
  parameter int PAW = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire mxd_pkg::mxd_cmd_type cmd,
  input wire logic [DAW-1:0] cmd_addr,
  output logic busy,
  output logic done,
  output logic skip,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [DAW-1:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata,
  output logic pmem_rd,
  output logic [PAW-1:0] pmem_addr,
  input wire logic [15:0] pmem_rdata
);
  typedef enum logic [3:0] {
    s_idle = 4'b0001,
    s_wait = 4'b0010,
    s_exec = 4'b0100,
    s_skip = 4'b1000
  } mxd_state_type;

  mxd_state_type state;
  mxd_state_type next_state;
  mxd_pkg::mxd_cmd_type cur;
  mxd_pkg::mxd_flags_type flags;
  mxd_pkg::mxd_result_type res;
  logic [7:0] working_register;
  logic [7:0] table_pointer_low;
  logic [PAW-9:0] table_pointer_high;
  logic [7:0] table_high_byte_latch;
  logic [7:0] next_ptr_low;
  logic take;
  logic is_table;

  // table reads draw their operand from program memory
  function automatic logic table_op(input mxd_pkg::mxd_op_type op);
    return op inside {mxd_pkg::op_table_read_specific_page,
                      mxd_pkg::op_table_read_final_page,
                      mxd_pkg::op_preincrement_table_read,
                      mxd_pkg::op_preincrement_final_page_read};
  endfunction

  function automatic logic final_page(input mxd_pkg::mxd_op_type op);
    return op inside {mxd_pkg::op_table_read_final_page,
                      mxd_pkg::op_preincrement_final_page_read};
  endfunction

  // ops that need no memory operand read
  function automatic logic no_read(input mxd_pkg::mxd_op_type op);
    return table_op(op) || op inside {mxd_pkg::op_xor_imm,
      mxd_pkg::op_extended_clear, mxd_pkg::op_extended_move_to_mem,
      mxd_pkg::op_extended_decimal_adjust};
  endfunction

  // ops whose only flag effect is the zero flag
  function automatic logic zero_only(input mxd_pkg::mxd_op_type op);
    return op inside {mxd_pkg::op_xor_work, mxd_pkg::op_xor_mem,
      mxd_pkg::op_xor_imm, mxd_pkg::op_extended_bitwise_and,
      mxd_pkg::op_extended_bitwise_and_mem,
      mxd_pkg::op_extended_bitwise_or,
      mxd_pkg::op_extended_bitwise_or_mem,
      mxd_pkg::op_extended_complement,
      mxd_pkg::op_extended_complement_work,
      mxd_pkg::op_extended_decrement, mxd_pkg::op_extended_decrement_work,
      mxd_pkg::op_extended_increment, mxd_pkg::op_extended_increment_work};
  endfunction

  // the whole instruction set evaluated on one operand
  function automatic mxd_pkg::mxd_result_type alu(
    input mxd_pkg::mxd_cmd_type c,
    input logic [7:0] work,
    input logic [7:0] m,
    input mxd_pkg::mxd_flags_type f
  );
    mxd_pkg::mxd_result_type r;
    logic [8:0] sum;
    logic [4:0] low;
    logic cin;
    logic lo_adj;
    logic hi_adj;
    r = '{value: m, to_work: 1'b0, to_mem: 1'b0, skip: 1'b0, flags: f};
    sum = 9'h000;
    low = 5'h00;
    cin = 1'b0;
    lo_adj = 1'b0;
    hi_adj = 1'b0;
    unique case (c.op)
      mxd_pkg::op_skip_zero_with_move:
      begin
        r.to_work = 1'b1;
        r.skip = (m == 8'h00);
      end
      mxd_pkg::op_skip_if_zero: r.skip = (m == 8'h00);
      mxd_pkg::op_skip_if_zero_bit: r.skip = ~m[c.bit_sel];
      mxd_pkg::op_table_read_specific_page,
      mxd_pkg::op_table_read_final_page,
      mxd_pkg::op_preincrement_table_read,
      mxd_pkg::op_preincrement_final_page_read:
        r.to_mem = 1'b1;
      mxd_pkg::op_xor_work,
      mxd_pkg::op_xor_mem:
      begin
        r.value = work ^ m;
        r.to_mem = (c.op == mxd_pkg::op_xor_mem);
        r.to_work = ~r.to_mem;
      end
      mxd_pkg::op_xor_imm:
      begin
        r.value = work ^ c.imm;
        r.to_work = 1'b1;
      end
      mxd_pkg::op_extended_add,
      mxd_pkg::op_extended_add_mem,
      mxd_pkg::op_extended_add_with_carry,
      mxd_pkg::op_extended_add_with_carry_mem:
      begin
        cin = f.c & (c.op inside {mxd_pkg::op_extended_add_with_carry,
          mxd_pkg::op_extended_add_with_carry_mem});
        sum = {1'b0, work} + {1'b0, m} + {8'h00, cin};
        low = {1'b0, work[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
        r.value = sum[7:0];
        r.flags.c = sum[8];
        r.flags.auxiliary_carry_flag = low[4];
        r.flags.signed_range_exceeded_flag = (work[7] == m[7])
          && (sum[7] != work[7]);
        r.flags.signed_carry_flag = r.flags.signed_range_exceeded_flag
          ^ sum[7]; // true sign of the sum
        r.to_mem = c.op inside {mxd_pkg::op_extended_add_mem,
          mxd_pkg::op_extended_add_with_carry_mem};
        r.to_work = ~r.to_mem;
      end
      mxd_pkg::op_extended_bitwise_and,
      mxd_pkg::op_extended_bitwise_and_mem:
      begin
        r.value = work & m;
        r.to_mem = (c.op == mxd_pkg::op_extended_bitwise_and_mem);
        r.to_work = ~r.to_mem;
      end
      mxd_pkg::op_extended_bitwise_or,
      mxd_pkg::op_extended_bitwise_or_mem:
      begin
        r.value = work | m;
        r.to_mem = (c.op == mxd_pkg::op_extended_bitwise_or_mem);
        r.to_work = ~r.to_mem;
      end
      mxd_pkg::op_extended_clear:
      begin
        r.value = mxd_pkg::CLEAR_VALUE;
        r.to_mem = 1'b1;
      end
      mxd_pkg::op_extended_clear_bit:
      begin
        r.value[c.bit_sel] = 1'b0;
        r.to_mem = 1'b1;
      end
      mxd_pkg::op_extended_complement,
      mxd_pkg::op_extended_complement_work:
      begin
        r.value = ~m;
        r.to_work = (c.op == mxd_pkg::op_extended_complement_work);
        r.to_mem = ~r.to_work;
      end
      mxd_pkg::op_extended_decimal_adjust:
      begin
        lo_adj = (work[3:0] > mxd_pkg::NIBBLE_MAX)
          || f.auxiliary_carry_flag;
        hi_adj = (work[7:4] > mxd_pkg::NIBBLE_MAX) || f.c;
        r.value = work + {hi_adj ? mxd_pkg::BCD_STEP : 4'h0,
                         lo_adj ? mxd_pkg::BCD_STEP : 4'h0};
        r.flags.c = hi_adj;
        r.to_mem = 1'b1;
      end
      mxd_pkg::op_extended_decrement,
      mxd_pkg::op_extended_decrement_work:
      begin
        r.value = m - mxd_pkg::ONE;
        r.to_work = (c.op == mxd_pkg::op_extended_decrement_work);
        r.to_mem = ~r.to_work;
      end
      mxd_pkg::op_extended_increment,
      mxd_pkg::op_extended_increment_work:
      begin
        r.value = m + mxd_pkg::ONE;
        r.to_work = (c.op == mxd_pkg::op_extended_increment_work);
        r.to_mem = ~r.to_work;
      end
      mxd_pkg::op_extended_move_to_work: r.to_work = 1'b1;
      mxd_pkg::op_extended_move_to_mem:
      begin
        r.value = work;
        r.to_mem = 1'b1;
      end
      mxd_pkg::op_extended_rotate_left,
      mxd_pkg::op_extended_rotate_left_work:
      begin
        r.value = {m[6:0], m[7]};
        r.to_work = (c.op == mxd_pkg::op_extended_rotate_left_work);
        r.to_mem = ~r.to_work;
      end
      mxd_pkg::op_extended_rotate_left_carry,
      mxd_pkg::op_extended_rotate_left_carry_work:
      begin
        r.value = {m[6:0], f.c};
        r.flags.c = m[7];
        r.to_work = (c.op == mxd_pkg::op_extended_rotate_left_carry_work);
        r.to_mem = ~r.to_work;
      end
      default: r.to_work = 1'b0; // undefined codes do nothing
    endcase
    // zero flag follows the stored byte
    if (zero_only(c.op) || c.op inside {mxd_pkg::op_extended_add,
        mxd_pkg::op_extended_add_mem, mxd_pkg::op_extended_add_with_carry,
        mxd_pkg::op_extended_add_with_carry_mem})
    begin
      r.flags.z = (r.value == 8'h00);
    end
    return r;
  endfunction

  assign take = cmd_valid && (state == s_idle);
  assign is_table = table_op(cur.op);
  assign next_ptr_low = table_pointer_low + mxd_pkg::ONE;

  // operand is the program low byte for table reads
  always_comb
  begin
    res = alu(cur, working_register,
              is_table ? pmem_rdata[7:0] : dmem_rdata, flags);
  end

  // sequencing; every command takes the same path to done, a met skip then adds s_skip
  always_comb
  begin
    next_state = state;
    unique case (state)
      s_idle: if (take) next_state = s_wait;
      s_wait: next_state = s_exec;
      s_exec: next_state = res.skip ? s_skip : s_idle;
      s_skip: next_state = s_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= s_idle;
      busy <= 1'b0;
      done <= 1'b0;
      skip <= 1'b0;
      cur <= '0;
    end
    else
    begin
      state <= next_state;
      busy <= (next_state != s_idle);
      done <= (state == s_exec);
      skip <= (state == s_exec) && res.skip;
      if (take)
        cur <= cmd;
    end
  end

  // memory requests; full address width reaches every section
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dmem_rd <= 1'b0;
      dmem_wr <= 1'b0;
      dmem_addr <= '0;
      dmem_wdata <= 8'h00;
      pmem_rd <= 1'b0;
      pmem_addr <= '0;
    end
    else
    begin
      dmem_rd <= take && !no_read(cmd.op);
      pmem_rd <= take && table_op(cmd.op);
      dmem_wr <= (state == s_exec) && res.to_mem;
      if (take)
        dmem_addr <= cmd_addr;
      if (state == s_exec)
        dmem_wdata <= res.value;
      if (take && table_op(cmd.op))
      begin
        if (cmd.op inside {mxd_pkg::op_preincrement_table_read,
            mxd_pkg::op_preincrement_final_page_read})
        begin
          pmem_addr <= final_page(cmd.op) ? {{(PAW-8){1'b1}},
            next_ptr_low} : {table_pointer_high, next_ptr_low};
        end
        else
        begin
          pmem_addr <= final_page(cmd.op) ? {{(PAW-8){1'b1}},
            table_pointer_low}
            : {table_pointer_high, table_pointer_low};
        end
      end
    end
  end

  // architectural state; the datapath wins over a port write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      working_register <= mxd_pkg::WORKING_RESET;
      flags <= mxd_pkg::STATUS_RESET;
      table_pointer_low <= mxd_pkg::PTR_RESET;
      table_pointer_high <= '0;
      table_high_byte_latch <= mxd_pkg::PTR_RESET;
    end
    else
    begin
      if (state == s_exec && res.to_work)
        working_register <= res.value;
      else if (reg_wr && reg_addr == mxd_pkg::REG_WORKING)
        working_register <= reg_wdata;
      if (state == s_exec)
        flags <= res.flags;
      else if (reg_wr && reg_addr == mxd_pkg::REG_STATUS)
        flags <= reg_wdata[4:0];
      if (take && cmd.op inside {mxd_pkg::op_preincrement_table_read,
          mxd_pkg::op_preincrement_final_page_read})
        table_pointer_low <= next_ptr_low;
      else if (reg_wr && reg_addr == mxd_pkg::REG_PTR_LOW)
        table_pointer_low <= reg_wdata;
      if (reg_wr && reg_addr == mxd_pkg::REG_PTR_HIGH)
        table_pointer_high <= reg_wdata[PAW-9:0];
      if (state == s_exec && is_table)
        table_high_byte_latch <= pmem_rdata[15:8];
      else if (reg_wr && reg_addr == mxd_pkg::REG_HIGH_LATCH)
        table_high_byte_latch <= reg_wdata;
    end
  end

  // register port readback, unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        mxd_pkg::REG_WORKING: reg_rdata <= working_register;
        mxd_pkg::REG_STATUS: reg_rdata <= {3'h0, flags};
        mxd_pkg::REG_PTR_LOW: reg_rdata <= table_pointer_low;
        mxd_pkg::REG_PTR_HIGH: reg_rdata <= 8'(table_pointer_high);
        mxd_pkg::REG_HIGH_LATCH: reg_rdata <= table_high_byte_latch;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  a_fixed_latency: assert property (@(posedge clk) disable iff (!rst_b)
    take |-> ##3 done) else $error("done not three cycles after take");
  a_skip_dummy: assert property (@(posedge clk) disable iff (!rst_b)
    skip |-> busy ##1 !busy) else $error("skip dummy cycle wrong");
  a_move_skip: assert property (@(posedge clk) disable iff (!rst_b)
    state == s_exec && cur.op == mxd_pkg::op_skip_zero_with_move
    |=> working_register == $past(dmem_rdata)
        && skip == ($past(dmem_rdata) == 8'h00)
        && flags == $past(flags)) else $error("move skip wrong");
  a_bit_skip: assert property (@(posedge clk) disable iff (!rst_b)
    state == s_exec && cur.op == mxd_pkg::op_skip_if_zero_bit
    |=> skip != $past(dmem_rdata[cur.bit_sel]))
    else $error("bit test skip wrong");
  a_final_page: assert property (@(posedge clk) disable iff (!rst_b)
    pmem_rd && final_page(cur.op) |-> &pmem_addr[PAW-1:8])
    else $error("final page not addressed");
  a_preinc_ptr: assert property (@(posedge clk) disable iff (!rst_b)
    take && cmd.op == mxd_pkg::op_preincrement_table_read
    |=> pmem_addr[7:0] == table_pointer_low
        && table_pointer_low == 8'($past(table_pointer_low) + 8'h01))
    else $error("preincrement wrong");
  a_xor_imm: assert property (@(posedge clk) disable iff (!rst_b)
    state == s_exec && cur.op == mxd_pkg::op_xor_imm
    |=> working_register == ($past(working_register) ^ $past(cur.imm)))
    else $error("xor immediate wrong");
  a_clear_write: assert property (@(posedge clk) disable iff (!rst_b)
    state == s_exec && cur.op == mxd_pkg::op_extended_clear
    |=> dmem_wr && dmem_wdata == 8'h00 && flags == $past(flags))
    else $error("clear wrong");
  a_rotate_carry: assert property (@(posedge clk) disable iff (!rst_b)
    state == s_exec && cur.op == mxd_pkg::op_extended_rotate_left_carry
    |=> dmem_wdata == {$past(dmem_rdata[6:0]), $past(flags.c)}
        && flags.c == $past(dmem_rdata[7])) else $error("rlc wrong");
  a_zero_flag: assert property (@(posedge clk) disable iff (!rst_b)
    state == s_exec && zero_only(cur.op)
    |=> flags.z == ($past(res.value) == 8'h00)
        && flags.c == $past(flags.c)) else $error("zero flag wrong");
endmodule

// File: test/mxd_mem.sv
// Purpose: data and program memory on the far side of the datapath
// Assumes: a read answers in the cycle after its strobe
// Notes: program words are their address folded with a fixed mask
`timescale 1ns/10ps
module mxd_mem #(
  parameter int DAW = 12,
  parameter int PAW = 16,
  parameter logic [15:0] PMASK = 16'h5ac3
) (
  input wire logic clk,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic [DAW-1:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata,
  input wire logic pmem_rd,
  input wire logic [PAW-1:0] pmem_addr,
  output logic [15:0] pmem_rdata
);
  // the bench preloads bytes here, so no always_ff
  logic [7:0] mem [0:(1<<DAW)-1];

  // data stands one cycle, then flips every cycle so a sample one cycle late never matches
  always @(posedge clk)
  begin
    if (dmem_wr)
      mem[dmem_addr] <= dmem_wdata;
    dmem_rdata <= dmem_rd ? mem[dmem_addr] : ~dmem_rdata;
    pmem_rdata <= pmem_rd ? 16'(pmem_addr) ^ PMASK : ~pmem_rdata;
  end
endmodule

// File: test/tb.sv
// Purpose: self-checking bench for the execution datapath
// Assumes: done two edges after the take edge, register reads one late
// Notes: each scenario is a task; t_alu results are predicted by ref_op
`timescale 1ns/10ps
module tb;
  localparam logic [15:0] PMASK = 16'h5ac3;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  mxd_pkg::mxd_cmd_type cmd = '0;
  logic [11:0] cmd_addr = 12'h000;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic busy, done, skip, dmem_rd, dmem_wr, pmem_rd;
  logic [7:0] reg_rdata, dmem_wdata, dmem_rdata;
  logic [11:0] dmem_addr;
  logic [15:0] pmem_addr, pmem_rdata;
  int miscompares = 0;
  int total_checks = 0;

  mxd_core #(.DAW(12), .PAW(16)) DUT (.clk(clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr), .busy(busy),
    .done(done), .skip(skip), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .pmem_rd(pmem_rd),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));

  mxd_mem #(.DAW(12), .PAW(16), .PMASK(PMASK)) mem_i (.clk(clk),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .pmem_rd(pmem_rd),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));

  always #25 clk = ~clk;

  task automatic check(input string w, input logic [15:0] seen,
      input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // register port cycles, strobes one cycle long
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic creg(input logic [3:0] a, input logic [7:0] e,
      input string w);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(w, 16'(reg_rdata), 16'(e));
  endtask

  // one command; a skip must hold busy through the dummy cycle
  task automatic run(input logic [5:0] op, input logic [11:0] a,
      input logic [7:0] imm, input logic [2:0] b, output logic sk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= mxd_pkg::mxd_cmd_type'({op, imm, b});
    cmd_addr <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("done", 16'(done), 16'h0001);
    sk = skip;
    check("busy in dummy", 16'(busy), 16'(skip));
    @(negedge clk);
    check("done pulse", 16'(done | busy), 16'h0000);
  endtask

  // reference result: {to working, to memory, value, flags}
  function automatic logic [14:0] ref_op(input logic [5:0] op,
      input logic [7:0] a, input logic [7:0] m, input logic [7:0] imm,
      input logic [2:0] b, input logic [4:0] f);
    logic [8:0] s;
    logic [4:0] l;
    logic [7:0] v;
    logic ci;
    logic hi;
    logic lo;
    mxd_pkg::mxd_flags_type nf;
    nf = f;
    ci = f[0] & (op == 6'h0c || op == 6'h0d);
    s = 9'(a) + 9'(m) + 9'(ci);
    l = 5'(a[3:0]) + 5'(m[3:0]) + 5'(ci);
    hi = a[7:4] > 4'h9 || f[0];
    lo = a[3:0] > 4'h9 || f[1];
    case (op)
      6'h07, 6'h08: v = a ^ m;
      6'h09: v = a ^ imm;
      6'h0a, 6'h0b, 6'h0c, 6'h0d: v = s[7:0];
      6'h0e, 6'h0f: v = a & m;
      6'h10, 6'h11: v = a | m;
      6'h12: v = 8'h00;
      6'h13: v = m & ~(8'h01 << b);
      6'h14, 6'h15: v = ~m;
      6'h16: v = a + {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
      6'h17, 6'h18: v = m - 8'h01;
      6'h19, 6'h1a: v = m + 8'h01;
      6'h1b: v = m;
      6'h1c: v = a;
      6'h1d, 6'h1e: v = {m[6:0], m[7]};
      default: v = {m[6:0], f[0]};
    endcase
    if (op >= 6'h0a && op <= 6'h0d)
    begin
      nf.c = s[8];
      nf.auxiliary_carry_flag = l[4];
      nf.signed_range_exceeded_flag = (a[7] == m[7]) && (s[7] != a[7]);
      nf.signed_carry_flag = nf.signed_range_exceeded_flag ^ s[7];
    end
    if (op == 6'h16)
      nf.c = hi;
    if (op >= 6'h1f)
      nf.c = m[7];
    if (op <= 6'h11 || op inside {6'h14, 6'h15, [6'h17:6'h1a]})
      nf.z = (v == 8'h00);
    return {op inside {6'h07, 6'h09, 6'h0a, 6'h0c, 6'h0e, 6'h10, 6'h15,
        6'h18, 6'h1a, 6'h1b, 6'h1e, 6'h20},
      op inside {6'h08, 6'h0b, 6'h0d, 6'h0f, 6'h11, 6'h12, 6'h13, 6'h14,
        6'h16, 6'h17, 6'h19, 6'h1c, 6'h1d, 6'h1f}, v, 5'(nf)};
  endfunction

  // every offset reads 00 after reset, unmapped writes vanish
  task automatic t_reset;
    wreg(4'h9, 8'hff);
    for (int i = 0; i < 16; i++)
      creg(4'(i), 8'h00, "reset value");
    $display("test reset done");
  endtask

  task automatic t_skip;
    logic [7:0] mv [6] = '{8'h00, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h01};
    logic sk;
    for (int i = 0; i < 6; i++)
    begin
      mem_i.mem[12'h3a0] = mv[i];
      wreg(mxd_pkg::REG_WORKING, 8'h5a);
      wreg(mxd_pkg::REG_STATUS, 8'h1f);
      run(6'(i / 2), 12'h3a0, 8'h00, (i == 4) ? 3'h7 : 3'h0, sk);
      check("skip", 16'(sk), 16'(i % 2 == 0));
      creg(mxd_pkg::REG_WORKING, (i < 2) ? mv[i] : 8'h5a, "working");
      creg(mxd_pkg::REG_STATUS, 8'h1f, "flags kept");
    end
    $display("test skip done");
  endtask

  // pointer low starts at ff so the preincrement wraps
  task automatic t_table;
    logic [5:0] ops [4] = '{6'h03, 6'h05, 6'h04, 6'h06};
    logic [7:0] lo;
    logic [15:0] w;
    logic sk;
    lo = 8'hff;
    wreg(mxd_pkg::REG_PTR_HIGH, 8'h12);
    wreg(mxd_pkg::REG_PTR_LOW, lo);
    for (int i = 0; i < 4; i++)
    begin
      lo = lo + 8'(i % 2);
      w = {(i >= 2) ? 8'hff : 8'h12, lo} ^ PMASK;
      run(ops[i], 12'h7c5 + 12'(i), 8'h00, 3'h0, sk);
      check("no skip", 16'(sk), 16'h0000);
      check("table low", 16'(mem_i.mem[12'h7c5 + 12'(i)]), 16'(w[7:0]));
      creg(mxd_pkg::REG_HIGH_LATCH, w[15:8], "latch");
      creg(mxd_pkg::REG_PTR_LOW, lo, "pointer low");
    end
    $display("test table done");
  endtask

  // all remaining codes over four operand sets, addresses spread wide
  task automatic t_alu;
    logic [7:0] av [4] = '{8'h12, 8'h9a, 8'ha5, 8'hb3};
    logic [7:0] mv [4] = '{8'h00, 8'h66, 8'h80, 8'hff};
    logic [4:0] fv [4] = '{5'h00, 5'h14, 5'h0b, 5'h15};
    logic [14:0] r;
    logic [11:0] ad;
    logic sk;
    for (int v = 0; v < 4; v++)
      for (int k = 7; k <= 32; k++)
      begin
        ad = 12'(k * 149 + v);
        mem_i.mem[ad] = mv[v];
        wreg(mxd_pkg::REG_WORKING, av[v]);
        wreg(mxd_pkg::REG_STATUS, {3'h0, fv[v]});
        run(6'(k), ad, mv[v], 3'(k), sk);
        check("no skip", 16'(sk), 16'h0000);
        r = ref_op(6'(k), av[v], mv[v], mv[v], 3'(k), fv[v]);
        creg(mxd_pkg::REG_WORKING, r[14] ? r[12:5] : av[v], "working");
        creg(mxd_pkg::REG_STATUS, {3'h0, r[4:0]}, "flags");
        check("memory", 16'(mem_i.mem[ad]), 16'(r[13] ? r[12:5] : mv[v]));
      end
    $display("test alu done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_skip();
    t_table();
    t_alu();
    final_report();
  end
endmodule
